// file: rtl/cpsr_defs.svh
// Operation
// - coarse mode adds divide-by-two before dividers
// - coarse skew unit twice the fine unit
// - output divider above 64 is unsupported
// - two select pins pick profile zero to three
// - per-profile dividers, filter, skews, delay compensation
// - shared settings apply to every profile
// - power-up reset acts like external reset but forces profile zero and the base relock wait
// - reset clears dividers, drops lock, relock grows
// - phase alignment valid only with lock high
// - gate low holds gated banks at polarity level
// - group enable high puts assigned banks high-Z
// - skew 0..15 units, eighth or quarter period
// - gate starts and stops without runt pulses
`ifndef CPSR_DEFS_SVH
`define CPSR_DEFS_SVH

`define CPSR_NUM_BANKS     5
`define CPSR_ADDR_W        8
`define CPSR_ADDR_CTRL     8'h00
`define CPSR_ADDR_ENABLE   8'h04
`define CPSR_ADDR_UES      8'h08
`define CPSR_ADDR_STATUS   8'h0C
`define CPSR_ADDR_ACTIVE   8'h10
`define CPSR_PROF_PAGE     2'h1
`define CPSR_CTRL_COARSE   0
`define CPSR_CTRL_INV_LSB  8
`define CPSR_CTRL_GATE_LSB 16
`define CPSR_CTRL_RST      32'h0000_0000
`define CPSR_ENABLE_RST    32'h0000_0155
`define CPSR_UES_RST       32'h0000_0000
`define CPSR_PROF_W0_RST   32'h0000_0101
`define CPSR_PROF_W1_RST   32'h0808_0808
`define CPSR_PROF_W2_RST   32'h0000_0008
`define CPSR_PROF_W3_RST   32'h0000_0000
`define CPSR_DIV_MAX       8'h40
`define CPSR_OSC_FINE_LAST 4'h7
`define CPSR_OSC_COARSE_LAST 4'hF
`define CPSR_HIST_W        31
`define CPSR_RESP_OKAY     2'h0
`define CPSR_RESP_SLVERR   2'h2

`endif

// file: rtl/cpsr_pkg.sv
package cpsr_pkg;
  // pin inputs travelling together
  typedef struct packed {
    logic profile_sel_hi;
    logic profile_sel_lo;
    logic reset_req;
    logic sync_output_gate;
    logic group_x_enable_n;
    logic group_y_enable_n;
    logic global_enable_n;
  } cpsr_pins_t;

  // lock acquisition states
  typedef enum logic [2:0] {
    LK_RESET  = 3'b001,
    LK_ACQ    = 3'b010,
    LK_LOCKED = 3'b100
  } cpsr_lock_t;

  // per-bank enable selection
  typedef enum logic [1:0] {
    EN_OFF = 2'h0,
    EN_ON  = 2'h1,
    EN_X   = 2'h2,
    EN_Y   = 2'h3
  } cpsr_en_t;
endpackage

// file: rtl/cpsr_top.sv
`timescale 1ns/1ns
`include "cpsr_defs.svh"
module cpsr_top #(
  parameter int unsigned LOCK_BASE_CYCLES = 64
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire cpsr_pkg::cpsr_pins_t     ctl_pins,
  output logic [`CPSR_NUM_BANKS-1:0]    bank_clk_out,
  output logic [`CPSR_NUM_BANKS-1:0]    bank_clk_oe,
  output logic                          lock,
  output logic                          fb_enable
);
  localparam int NB = `CPSR_NUM_BANKS;

  // address decode shared by read and write paths
  function automatic logic cpsr_mapped(input logic [7:0] a, input logic rd);
    cpsr_mapped = (a[7:6] == `CPSR_PROF_PAGE) || a == `CPSR_ADDR_CTRL ||
                  a == `CPSR_ADDR_ENABLE || a == `CPSR_ADDR_UES ||
                  (rd && (a == `CPSR_ADDR_STATUS || a == `CPSR_ADDR_ACTIVE));
  endfunction

  // byte-lane merge
  function automatic logic [31:0] cpsr_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
    cpsr_merge = o;
  endfunction

  // divider value legal range 1..64
  function automatic logic cpsr_div_ok(input logic [7:0] d);
    cpsr_div_ok = (d != 8'h00) && (d <= `CPSR_DIV_MAX);
  endfunction

  // pin synchroniser, first stage read only by second
  cpsr_pkg::cpsr_pins_t pins_m;
  cpsr_pkg::cpsr_pins_t pins_s;
  always_ff @(posedge aclk) begin
    pins_m <= ctl_pins;
    pins_s <= pins_m;
  end

  // power-up reset and pin reset both assert div_rst
  logic div_rst;
  assign div_rst = !aresetn || pins_s.reset_req;

  // register file
  logic [31:0]      ctrl;
  logic [31:0]      enable;
  logic [31:0]      user_signature;
  logic [31:0]      prof_mem [0:15];
  logic [31:0]      next_ctrl;
  logic [31:0]      next_enable;
  logic [31:0]      next_ues;
  logic [31:0]      next_prof_mem [0:15];
  logic             aw_have;
  logic [7:0]       aw_addr;
  logic             w_have;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             next_aw_have;
  logic [7:0]       next_aw_addr;
  logic             next_w_have;
  logic [31:0]      next_w_data;
  logic [3:0]       next_w_strb;
  logic             next_awready;
  logic             next_wready;
  logic             next_bvalid;
  logic [1:0]       next_bresp;
  logic             next_arready;
  logic             next_rvalid;
  logic [31:0]      next_rdata;
  logic [1:0]       next_rresp;
  logic [31:0]      rd_mux;
  logic [31:0]      status;
  logic [1:0]       act_prof;
  logic             unsupported;

  // write channel: address and data taken in either order
  always_comb begin
    next_ctrl    = ctrl;
    next_enable  = enable;
    next_ues     = user_signature;
    next_prof_mem = prof_mem;
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have  = w_have;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = cpsr_mapped(aw_addr, 1'b0) ? `CPSR_RESP_OKAY : `CPSR_RESP_SLVERR;
      if (aw_addr[7:6] == `CPSR_PROF_PAGE) begin
        next_prof_mem[aw_addr[5:2]] = cpsr_merge(prof_mem[aw_addr[5:2]], w_data, w_strb);
      end else if (aw_addr == `CPSR_ADDR_CTRL) begin
        next_ctrl = cpsr_merge(ctrl, w_data, w_strb);
      end else if (aw_addr == `CPSR_ADDR_ENABLE) begin
        next_enable = cpsr_merge(enable, w_data, w_strb);
      end else if (aw_addr == `CPSR_ADDR_UES) begin
        next_ues = cpsr_merge(user_signature, w_data, w_strb);
      end
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
  end

  // read mux
  always_comb begin
    unique case (s_axi_araddr)
      `CPSR_ADDR_CTRL:   rd_mux = ctrl;
      `CPSR_ADDR_ENABLE: rd_mux = enable;
      `CPSR_ADDR_UES:    rd_mux = user_signature;
      `CPSR_ADDR_STATUS: rd_mux = status;
      `CPSR_ADDR_ACTIVE: rd_mux = prof_mem[{act_prof, 2'h0}];
      default:           rd_mux = (s_axi_araddr[7:6] == `CPSR_PROF_PAGE) ?
                                  prof_mem[s_axi_araddr[5:2]] : 32'h0000_0000;
    endcase
  end

  // read channel
  always_comb begin
    next_arready = !s_axi_rvalid;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = rd_mux;
      next_rresp   = cpsr_mapped(s_axi_araddr, 1'b1) ? `CPSR_RESP_OKAY : `CPSR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  // bus and register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl          <= `CPSR_CTRL_RST;
      enable        <= `CPSR_ENABLE_RST;
      user_signature           <= `CPSR_UES_RST;
      for (int i = 0; i < 16; i += 4) begin
        prof_mem[i]   <= `CPSR_PROF_W0_RST;
        prof_mem[i+1] <= `CPSR_PROF_W1_RST;
        prof_mem[i+2] <= `CPSR_PROF_W2_RST;
        prof_mem[i+3] <= `CPSR_PROF_W3_RST;
      end
      aw_have       <= 1'b0;
      aw_addr       <= 8'h00;
      w_have        <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CPSR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CPSR_RESP_OKAY;
    end else begin
      ctrl          <= next_ctrl;
      enable        <= next_enable;
      user_signature           <= next_ues;
      prof_mem      <= next_prof_mem;
      aw_have       <= next_aw_have;
      aw_addr       <= next_aw_addr;
      w_have        <= next_w_have;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // active profile words and shared controls
  logic        coarse;
  logic [31:0] act_w0;
  logic [31:0] act_w1;
  logic [31:0] act_w2;
  logic [31:0] act_w3;
  logic [7:0]  div_val [NB];
  logic [3:0]  skew    [NB];
  assign coarse = ctrl[`CPSR_CTRL_COARSE];
  assign act_w0 = prof_mem[{act_prof, 2'h0}];
  assign act_w1 = prof_mem[{act_prof, 2'h1}];
  assign act_w2 = prof_mem[{act_prof, 2'h2}];
  assign act_w3 = prof_mem[{act_prof, 2'h3}];
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      div_val[b] = act_w1[b*8 +: 8];
    end
    div_val[4] = act_w2[7:0];
    for (int b = 0; b < NB; b++) begin
      skew[b] = act_w3[b*4 +: 4];
    end
  end

  // clock generation state
  logic [1:0]        next_act_prof;
  logic [3:0]        osc_cnt;
  logic [3:0]        next_osc_cnt;
  logic              src_tick;
  logic [5:0]        div_cnt      [NB];
  logic [5:0]        next_div_cnt [NB];
  logic [NB-1:0]     gate_eff;
  logic [NB-1:0]     next_gate_eff;
  logic [NB-1:0]     gated;
  logic [`CPSR_HIST_W-1:0] hist      [NB];
  logic [`CPSR_HIST_W-1:0] next_hist [NB];
  logic [NB-1:0]     next_clk_out;
  logic [NB-1:0]     next_clk_oe;
  logic              next_unsupported;

  // oscillator ticks, dividers, gating, skew lines, enables
  always_comb begin
    logic [4:0]  tap;
    logic [7:0]  last;
    logic [31:0] line;
    logic        dok;
    cpsr_pkg::cpsr_en_t mode;
    tap  = 5'h00;
    last = 8'h00;
    line = 32'h0000_0000;
    dok  = 1'b0;
    mode = cpsr_pkg::EN_OFF;
    next_act_prof = div_rst ? {pins_s.profile_sel_hi, pins_s.profile_sel_lo} : act_prof;
    src_tick     = osc_cnt == (coarse ? `CPSR_OSC_COARSE_LAST : `CPSR_OSC_FINE_LAST);
    next_osc_cnt = (div_rst || src_tick) ? 4'h0 : osc_cnt + 4'h1;
    next_unsupported = !cpsr_div_ok(act_w0[15:8]);
    for (int b = 0; b < NB; b++) begin
      dok  = cpsr_div_ok(div_val[b]);
      next_unsupported = next_unsupported || !dok;
      last = div_val[b] - 8'h01;
      next_div_cnt[b] = div_cnt[b];
      next_gate_eff[b] = gate_eff[b];
      // gate changes only at the end of a low half or during reset, so no runt
      if (div_rst) begin
        next_div_cnt[b]  = 6'h00;
        next_gate_eff[b] = pins_s.sync_output_gate;
      end else if (src_tick) begin
        if ({2'h0, div_cnt[b]} >= last) begin
          next_div_cnt[b]  = 6'h00;
          next_gate_eff[b] = pins_s.sync_output_gate;
        end else begin
          next_div_cnt[b] = div_cnt[b] + 6'h01;
        end
      end
      gated[b] = dok && !div_rst && ({2'h0, div_cnt[b]} < ((div_val[b] + 8'h01) >> 1)) &&
                 (gate_eff[b] || !ctrl[`CPSR_CTRL_GATE_LSB + b]);
      next_hist[b] = {hist[b][`CPSR_HIST_W-2:0], gated[b]};
      tap  = coarse ? {skew[b], 1'b0} : {1'b0, skew[b]};
      line = {hist[b], gated[b]};
      next_clk_out[b] = line[tap] ^ ctrl[`CPSR_CTRL_INV_LSB + b];
      mode = cpsr_pkg::cpsr_en_t'(enable[b*2 +: 2]);
      unique case (mode)
        cpsr_pkg::EN_OFF: next_clk_oe[b] = 1'b0;
        cpsr_pkg::EN_ON:  next_clk_oe[b] = !pins_s.global_enable_n;
        cpsr_pkg::EN_X:   next_clk_oe[b] = !pins_s.global_enable_n &&
                                           !pins_s.group_x_enable_n;
        cpsr_pkg::EN_Y:   next_clk_oe[b] = !pins_s.global_enable_n &&
                                           !pins_s.group_y_enable_n;
      endcase
    end
  end

  // clock generation registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_prof     <= 2'h0;
      osc_cnt      <= 4'h0;
      gate_eff     <= '0;
      bank_clk_out <= '0;
      bank_clk_oe  <= '0;
      unsupported  <= 1'b0;
      for (int b = 0; b < NB; b++) begin
        div_cnt[b] <= 6'h00;
        hist[b]    <= '0;
      end
    end else begin
      act_prof     <= next_act_prof;
      osc_cnt      <= next_osc_cnt;
      gate_eff     <= next_gate_eff;
      bank_clk_out <= next_clk_out;
      bank_clk_oe  <= next_clk_oe;
      unsupported  <= next_unsupported;
      div_cnt      <= next_div_cnt;
      hist         <= next_hist;
    end
  end

  // lock acquisition: wait grows with reset hold length
  cpsr_pkg::cpsr_lock_t lk_st;
  cpsr_pkg::cpsr_lock_t next_lk_st;
  logic [15:0] hold_cnt;
  logic [15:0] next_hold_cnt;
  logic [17:0] acq_cnt;
  logic [17:0] next_acq_cnt;
  always_comb begin
    next_lk_st    = lk_st;
    next_hold_cnt = hold_cnt;
    next_acq_cnt  = acq_cnt;
    unique case (lk_st)
      cpsr_pkg::LK_RESET: begin
        if (div_rst) begin
          if (hold_cnt != 16'hFFFF) begin
            next_hold_cnt = hold_cnt + 16'h0001;
          end
        end else begin
          next_lk_st   = cpsr_pkg::LK_ACQ;
          next_acq_cnt = 18'h00000;
        end
      end
      cpsr_pkg::LK_ACQ: begin
        if (div_rst) begin
          next_lk_st    = cpsr_pkg::LK_RESET;
          next_hold_cnt = 16'h0000;
        end else if (pins_s.global_enable_n) begin
          next_acq_cnt = 18'h00000; // feedback off: never locks
        end else if (acq_cnt >= 18'(LOCK_BASE_CYCLES) + {2'h0, hold_cnt}) begin
          next_lk_st = cpsr_pkg::LK_LOCKED;
        end else begin
          next_acq_cnt = acq_cnt + 18'h00001;
        end
      end
      cpsr_pkg::LK_LOCKED: begin
        if (div_rst) begin
          next_lk_st    = cpsr_pkg::LK_RESET;
          next_hold_cnt = 16'h0000;
        end else if (pins_s.global_enable_n) begin
          next_lk_st   = cpsr_pkg::LK_ACQ;
          next_acq_cnt = 18'h00000;
        end
      end
      default: begin
        next_lk_st = cpsr_pkg::LK_RESET;
      end
    endcase
  end

  // lock registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_st     <= cpsr_pkg::LK_RESET;
      hold_cnt  <= 16'h0000;
      acq_cnt   <= 18'h00000;
      lock      <= 1'b0;
      fb_enable <= 1'b0;
    end else begin
      lk_st     <= next_lk_st;
      hold_cnt  <= next_hold_cnt;
      acq_cnt   <= next_acq_cnt;
      lock      <= (next_lk_st == cpsr_pkg::LK_LOCKED) && !div_rst;
      fb_enable <= !pins_s.global_enable_n;
    end
  end

  // status word
  assign status = {20'h00000, pins_s, coarse, unsupported, act_prof, lock};
endmodule

// file: verification/cpsr_monitor.sv
`timescale 1ns/1ns
`include "cpsr_defs.svh"
module cpsr_monitor #(
  parameter int unsigned LOCK_BASE_CYCLES = 64
) (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic                        s_axi_rvalid,
  input wire cpsr_pkg::cpsr_pins_t        ctl_pins,
  input wire logic [`CPSR_NUM_BANKS-1:0]  bank_clk_oe,
  input wire logic                        lock,
  input wire logic                        fb_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [15:0] since;
  logic [15:0] next_since;

  // cycles since reset was last requested, saturating
  always_comb begin
    next_since = (since == 16'hFFFF) ? since : since + 16'h0001;
    if (ctl_pins.reset_req) next_since = 16'h0000;
  end
  always_ff @(posedge aclk) begin
    since <= aresetn ? next_since : 16'h0000;
  end

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_rst_quiet;
    $rose(aresetn) |-> !lock && bank_clk_oe == '0;
  endproperty
  property p_lock_drop;
    ctl_pins.reset_req [*4] |-> !lock;
  endproperty
  property p_relock_early;
    $rose(lock) |-> since >= LOCK_BASE_CYCLES;
  endproperty
  property p_relock_bound;
    $rose(aresetn) |-> ##[1:300] lock;
  endproperty
  property p_global_off;
    ctl_pins.global_enable_n [*4] |-> !lock && !fb_enable && bank_clk_oe == '0;
  endproperty
  property p_fb_on;
    !ctl_pins.global_enable_n [*4] |-> fb_enable;
  endproperty
  property p_rd_ans;
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_wr_ans;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  a_lock_drop: assert property (p_lock_drop) else $error("lock high during reset");
  a_relock_early: assert property (p_relock_early) else $error("relock too early");
  a_relock_bound: assert property (p_relock_bound) else $error("no lock after reset");
  a_global_off: assert property (p_global_off) else $error("global disable ignored");
  a_fb_on: assert property (p_fb_on) else $error("feedback not enabled");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
endmodule

// file: verification/cpsr_board_model.sv
`timescale 1ns/1ns
module cpsr_board_model (
  input  wire logic            aclk,
  input  wire logic [1:0]      sel,
  input  wire logic [7:0]      rst_len,
  input  wire logic            rst_go,
  input  wire logic            gate,
  input  wire logic [2:0]      en_n,
  output cpsr_pkg::cpsr_pins_t pins
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] next_cnt;

  // length of the reset request pulse
  always_comb begin
    next_cnt = cnt;
    if (rst_go) next_cnt = rst_len;
    else if (cnt != 8'h00) next_cnt = cnt - 8'h01;
  end
  always @(posedge aclk) begin
    cnt <= next_cnt;
  end

  // reset driven low when idle, enables as commanded
  assign pins = {sel, cnt != 8'h00, gate, en_n};
endmodule

// file: verification/tb.sv
`timescale 1ns/1ns
`include "cpsr_defs.svh"
module tb;
  typedef struct packed {
    logic [2:0] en_n;
    logic [4:0] oe;
  } cpsr_row_t;
  logic                       aclk = 1'b0;
  logic                       aresetn = 1'b0;
  logic [7:0]                 s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]                s_axi_wdata = 32'h0;
  logic                       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                       s_axi_rvalid, lock, fb_enable;
  logic [1:0]                 s_axi_bresp, s_axi_rresp;
  logic [31:0]                s_axi_rdata;
  logic [`CPSR_NUM_BANKS-1:0] bank_clk_out, bank_clk_oe;
  cpsr_pkg::cpsr_pins_t       ctl_pins;
  logic [1:0]                 sel = 2'h0;
  logic [7:0]                 rst_len = 8'h00;
  logic                       rst_go = 1'b0, gate = 1'b1;
  logic [2:0]                 en_n = 3'h0;
  int                         fails = 0, n_compared = 0, cyc = 0;
  cpsr_row_t                  rows [5] = '{'{3'h0, 5'h1F}, '{3'h4, 5'h1E}, '{3'h2, 5'h1D},
                                           '{3'h6, 5'h1C}, '{3'h1, 5'h00}};

  // clock and cycle count
  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  cpsr_top #(.LOCK_BASE_CYCLES(4)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ctl_pins, .bank_clk_out, .bank_clk_oe,
    .lock, .fb_enable
  );
  cpsr_board_model board_u (
    .aclk, .sel, .rst_len, .rst_go, .gate, .en_n, .pins(ctl_pins)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 500);
    s_axi_bready <= 1'b0;
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 500);
    s_axi_rready <= 1'b0;
    chk(s_axi_rvalid, 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
    chk(s_axi_rdata & e[31:0], e); 
  endtask

  // reset request pulse, then cycles until lock
  task automatic relock(input logic [7:0] n, output int t);
    int k;
    k = 0;
    rst_len <= n;
    rst_go <= 1'b1;
    @(posedge aclk);
    rst_go <= 1'b0;
    t = cyc;
    while (lock !== 1'b0 && k < 20) begin @(posedge aclk); k++; end
    while (lock !== 1'b1 && k < 2000) begin @(posedge aclk); k++; end
    t = cyc - t;
    chk(lock, 1'b1);
  endtask

  // cycle of the next rising edge of one bank
  task automatic rise(input int b, output int t);
    logic p;
    int   k;
    p = 1'b1;
    k = 0;
    while (k < 2000) begin
      @(posedge aclk);
      if (bank_clk_out[b] === 1'b1 && !p) break;
      p = bank_clk_out[b];
      k++;
    end
    t = cyc;
  endtask

  // main sequence
  initial begin
    int t0, t1, t2, ts;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    relock(8'h04, t0);
    wchk(8'h04, 32'h0000_015E, 2'h0);
    foreach (rows[i]) begin
      en_n <= rows[i].en_n;
      repeat (6) @(posedge aclk);
      chk(bank_clk_oe, rows[i].oe);
    end
    en_n <= 3'h0;
    wchk(8'h04, `CPSR_ENABLE_RST, 2'h0);
    $display("enable table done");
    for (int p = 0; p < 4; p++) wchk(8'(8'h40 + p * 16), {12'h000, 4'(p), 16'h0101}, 2'h0);
    for (int p = 0; p < 4; p++) begin
      sel <= 2'(p);
      relock(8'h04, t0);
      rchk(8'h10, {12'h000, 4'(p), 16'h0101}, 2'h0);
      rchk(8'h0C, {20'h00000, 2'(p), 5'h08, 2'h0, 2'(p), 1'b1}, 2'h0);
    end
    sel <= 2'h1;
    repeat (10) @(posedge aclk);
    rchk(8'h10, 32'h0003_0101, 2'h0);
    $display("profile test done");
    sel <= 2'h0;
    wchk(8'h4C, 32'h0000_00F0, 2'h0);
    for (int m = 0; m < 2; m++) begin
      wchk(8'h00, 32'(m), 2'h0);
      relock(8'h04, t0);
      rise(0, t0);
      rise(1, t1);
      rise(0, t2);
      chk(t1 - t0, 15 << m);
      chk(t2 - t0, 64 << m);
    end
    // coarse mode with halved dividers keeps the bank period
    wchk(8'h44, 32'h0404_0404, 2'h0);
    relock(8'h04, t0);
    rise(0, t0);
    rise(0, t1);
    chk(t1 - t0, 64);
    $display("skew mode test done");
    wchk(8'h00, 32'h0, 2'h0);
    wchk(8'h44, 32'h0841_4008, 2'h0);
    relock(8'h04, t0);
    rise(1, t0);
    rise(1, t1);
    chk(t1 - t0, 512);
    rchk(8'h0C, 32'h0000_0109, 2'h0);
    ts = 0;
    repeat (70) begin @(posedge aclk); ts += bank_clk_out[2]; end
    chk(ts, 0);
    wchk(8'h44, `CPSR_PROF_W1_RST, 2'h0);
    $display("divider limit test done");
    wchk(8'h00, 32'h0005_0400, 2'h0);
    relock(8'h04, t0);
    gate <= 1'b0;
    repeat (150) @(posedge aclk);
    ts = 0;
    t1 = 0;
    repeat (130) begin @(posedge aclk); ts += bank_clk_out[0]; t1 += bank_clk_out[2]; end
    chk(ts, 0);
    chk(t1, 130);
    gate <= 1'b1;
    rise(0, t0);
    t1 = 0;
    while (bank_clk_out[0] === 1'b1 && t1 < 200) begin @(posedge aclk); t1++; end
    chk(t1, 32);
    $display("gate test done");
    relock(8'h0A, t1);
    relock(8'h3C, t2);
    chk((t2 - t1 >= 95) && (t2 - t1 <= 105), 1'b1);
    $display("relock test done");
    wchk(8'h08, 32'hA5A5_0F0F, 2'h0);
    rchk(8'h08, 32'hA5A5_0F0F, 2'h0);
    wchk(8'h0C, 32'h1, 2'h2);
    rchk(8'h20, 32'h0, 2'h2);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    relock(8'h04, t0);
    rchk(8'h00, `CPSR_CTRL_RST, 2'h0);
    rchk(8'h08, `CPSR_UES_RST, 2'h0);
    rchk(8'h4C, `CPSR_PROF_W3_RST, 2'h0);
    $display("reset test done");
    test_done();
  end

  // watchdog
  initial begin
    #2000000;
    fails++;
    $display("Error at %0t ns: watchdog expired", $time);
    test_done();
  end
endmodule

bind cpsr_top cpsr_monitor #(.LOCK_BASE_CYCLES(LOCK_BASE_CYCLES)) mon_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ctl_pins, .bank_clk_oe,
  .lock, .fb_enable
);
